// >>> sdrtc_pkg.sv
package sdrtc_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [11:0] SDRTC_OFF_REFRESH  = 12'h000;
    localparam logic [11:0] SDRTC_OFF_READCFG  = 12'h004;
    localparam logic [11:0] SDRTC_OFF_PRECHG   = 12'h008;
    localparam logic [11:0] SDRTC_OFF_ACT2PRE  = 12'h00C;
    localparam logic [11:0] SDRTC_OFF_SREXIT   = 12'h010;
    localparam logic [11:0] SDRTC_OFF_STATUS   = 12'h014;

    // =====================================================================
    // field widths and positions
    localparam int SDRTC_REFRESH_W = 11;
    localparam int SDRTC_READCFG_W = 2;
    localparam int SDRTC_TIMING_W  = 4;
    localparam int SDRTC_FIELD_LSB = 0;
    localparam int SDRTC_PRESCALE_W = 4;

    // =====================================================================
    // reset values
    localparam logic [10:0] SDRTC_REFRESH_RST = 11'h000;
    localparam logic [1:0]  SDRTC_READCFG_RST = 2'h0;
    localparam logic [3:0]  SDRTC_TIMING_RST  = 4'hF;

    // =====================================================================
    // refresh prescale: 16 bus clock ticks per interval unit
    localparam logic [3:0]  SDRTC_PRESCALE_LAST = 4'hF;

    // =====================================================================
    // read capture strategies
    typedef enum logic [1:0] {
        SDRTC_RD_CLKOUT_DLY = 2'b00,
        SDRTC_RD_CMD_DLY    = 2'b01,
        SDRTC_RD_CMD_DLY_P1 = 2'b10,
        SDRTC_RD_CMD_DLY_P2 = 2'b11
    } sdrtc_rd_t;

    // apb access phases
    typedef enum logic [1:0] {
        SDRTC_ST_IDLE = 2'b00,
        SDRTC_ST_WAIT = 2'b01,
        SDRTC_ST_DONE = 2'b10
    } sdrtc_st_t;

    // timing outputs for the command sequencer
    typedef struct packed {
        logic                       cmd_delayed;
        logic                       use_feedback_clk;
        logic [1:0]                 extra_latency;
        logic [4:0]                 precharge_cycles;
        logic [4:0]                 act2pre_cycles;
        logic [4:0]                 srexit_cycles;
    } sdrtc_timing_t;

    typedef struct packed {
        sdrtc_st_t                  st;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic [10:0]                refresh_interval;
        logic [1:0]                 read_strategy;
        logic [3:0]                 precharge;
        logic [3:0]                 act2pre;
        logic [3:0]                 srexit;
        logic [3:0]                 prescale;
        logic [10:0]                count;
        logic                       pending;
        logic                       refresh_req;
        sdrtc_timing_t              timing;
    } sdrtc_state_t;

endpackage : sdrtc_pkg

// >>> sdrtc_refresh_timing.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// Contract
// - 11-bit refresh field, zero disables refresh
// - refresh spacing is 16 times n
// - refresh evenly spaced, issue may slip
// - refresh counter runs on bus clock
// - one setting serves all chip selects
// - strategy 00: delayed output clock capture
// - strategy 01: command delayed via feedback
// - 10/11 add one/two capture cycles
// - precharge code n gives n+1, F=16
// - active-to-precharge n+1, F=16
// - self-refresh exit n+1, F=16
// - every access takes one wait state
// - upper bits undefined, write zeros
module sdrtc_refresh_timing
    import sdrtc_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    // command sequencer side
    input  wire logic                refresh_ack,
    output logic                     refresh_req,
    output logic [10:0]              refresh_interval,
    output sdrtc_timing_t            timing
);

    // =====================================================================
    // helpers
    function automatic logic [4:0] sdrtc_cycles(input logic [3:0] code);
        sdrtc_cycles = {1'b0, code} + 5'h01;
    endfunction : sdrtc_cycles

    function automatic logic sdrtc_mapped(input logic [11:0] a);
        sdrtc_mapped = (a == SDRTC_OFF_REFRESH) || (a == SDRTC_OFF_READCFG) ||
                       (a == SDRTC_OFF_PRECHG) || (a == SDRTC_OFF_ACT2PRE) ||
                       (a == SDRTC_OFF_SREXIT) || (a == SDRTC_OFF_STATUS);
    endfunction : sdrtc_mapped

    // =====================================================================
    // state
    sdrtc_state_t s_reg;
    sdrtc_state_t s_next;
    logic         setup_seen;
    logic         wr_done;
    logic         rd_done;

    assign setup_seen = psel && !penable;
    assign wr_done    = psel && penable && pwrite && s_reg.pready;
    assign rd_done    = psel && penable && !pwrite && s_reg.pready;

    always_comb
    begin
        s_next         = s_reg;
        s_next.pslverr = 1'b0;
        s_next.pready  = 1'b0;
        // =================================================================
        // apb: setup, one wait cycle, then ready
        case (s_reg.st)
            SDRTC_ST_IDLE:
            begin
                if (setup_seen)
                begin
                    s_next.st = SDRTC_ST_WAIT;
                end
            end
            SDRTC_ST_WAIT:
            begin
                s_next.st     = SDRTC_ST_DONE;
                s_next.pready = 1'b1;
                s_next.pslverr = !sdrtc_mapped(paddr);
                s_next.prdata = 32'h0000_0000;
                case (paddr)
                    SDRTC_OFF_REFRESH: s_next.prdata[10:0] = s_reg.refresh_interval;
                    SDRTC_OFF_READCFG: s_next.prdata[1:0]  = s_reg.read_strategy;
                    SDRTC_OFF_PRECHG:  s_next.prdata[3:0]  = s_reg.precharge;
                    SDRTC_OFF_ACT2PRE: s_next.prdata[3:0]  = s_reg.act2pre;
                    SDRTC_OFF_SREXIT:  s_next.prdata[3:0]  = s_reg.srexit;
                    SDRTC_OFF_STATUS:  s_next.prdata[10:0] = s_reg.count;
                    default:           s_next.prdata       = 32'h0000_0000;
                endcase
            end
            SDRTC_ST_DONE:
            begin
                s_next.st = SDRTC_ST_IDLE;
            end
            default:
            begin
                s_next.st = SDRTC_ST_IDLE;
            end
        endcase
        // =================================================================
        // writes land at the completing edge
        if (s_reg.st == SDRTC_ST_DONE && psel && penable && pwrite)
        begin
            case (paddr)
                SDRTC_OFF_REFRESH: s_next.refresh_interval = pwdata[10:0];
                SDRTC_OFF_READCFG: s_next.read_strategy    = pwdata[1:0];
                SDRTC_OFF_PRECHG:  s_next.precharge        = pwdata[3:0];
                SDRTC_OFF_ACT2PRE: s_next.act2pre          = pwdata[3:0];
                SDRTC_OFF_SREXIT:  s_next.srexit           = pwdata[3:0];
                default:           s_next.srexit           = s_next.srexit;
            endcase
        end
        // =================================================================
        // refresh timer on the bus clock
        s_next.prescale = s_reg.prescale + 4'h1;
        if (s_reg.refresh_interval == 11'h000)
        begin
            s_next.prescale = 4'h0;
            s_next.count    = 11'h000;
            s_next.pending  = 1'b0;
        end
        else if (s_reg.prescale == SDRTC_PRESCALE_LAST)
        begin
            if (s_reg.count <= 11'h001)
            begin
                s_next.count   = s_reg.refresh_interval;
                s_next.pending = 1'b1;
            end
            else
            begin
                s_next.count = s_reg.count - 11'h001;
            end
        end
        // =================================================================
        // request held until the sequencer takes it
        if (s_reg.refresh_req && refresh_ack)
        begin
            s_next.refresh_req = 1'b0;
        end
        else if (s_reg.pending && !s_reg.refresh_req)
        begin
            s_next.refresh_req = 1'b1;
            s_next.pending     = s_next.pending && (s_reg.prescale == SDRTC_PRESCALE_LAST)
                                 && (s_reg.count <= 11'h001);
        end
        if (s_reg.refresh_interval == 11'h000)
        begin
            s_next.refresh_req = s_reg.refresh_req && !refresh_ack;
        end
        // =================================================================
        // decoded timing, shared by all chip selects
        s_next.timing.cmd_delayed      = (s_reg.read_strategy != SDRTC_RD_CLKOUT_DLY);
        s_next.timing.use_feedback_clk = (s_reg.read_strategy != SDRTC_RD_CLKOUT_DLY);
        case (s_reg.read_strategy)
            SDRTC_RD_CMD_DLY_P1: s_next.timing.extra_latency = 2'h1;
            SDRTC_RD_CMD_DLY_P2: s_next.timing.extra_latency = 2'h2;
            default:             s_next.timing.extra_latency = 2'h0;
        endcase
        s_next.timing.precharge_cycles = sdrtc_cycles(s_reg.precharge);
        s_next.timing.act2pre_cycles   = sdrtc_cycles(s_reg.act2pre);
        s_next.timing.srexit_cycles    = sdrtc_cycles(s_reg.srexit);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg                  <= '0;
            s_reg.st               <= SDRTC_ST_IDLE;
            s_reg.refresh_interval <= SDRTC_REFRESH_RST;
            s_reg.read_strategy    <= SDRTC_READCFG_RST;
            s_reg.precharge        <= SDRTC_TIMING_RST;
            s_reg.act2pre          <= SDRTC_TIMING_RST;
            s_reg.srexit           <= SDRTC_TIMING_RST;
            s_reg.timing           <= '{1'b0, 1'b0, 2'h0, 5'h10, 5'h10, 5'h10};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =====================================================================
    // outputs
    assign pready           = s_reg.pready;
    assign pslverr          = s_reg.pslverr;
    assign prdata           = s_reg.prdata;
    assign refresh_req      = s_reg.refresh_req;
    assign refresh_interval = s_reg.refresh_interval;
    assign timing           = s_reg.timing;

    // =====================================================================
    // assertions
    a_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> !pready ##1 pready)
        else $error("access did not take one wait state");

    a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held more than one cycle");

    a_refresh_off: assert property (@(posedge pclk) disable iff (!presetn)
        (refresh_interval == 11'h000 && !refresh_req) |=> !refresh_req)
        else $error("refresh raised while disabled");

    a_precharge_map: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(s_reg.precharge) |=> timing.precharge_cycles == {1'b0, $past(s_reg.precharge)} + 5'h01)
        else $error("precharge cycles wrong");

    a_act2pre_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 timing.act2pre_cycles == {1'b0, $past(s_reg.act2pre)} + 5'h01)
        else $error("active to precharge cycles wrong");

    a_srexit_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 timing.srexit_cycles == {1'b0, $past(s_reg.srexit)} + 5'h01)
        else $error("self refresh exit cycles wrong");

    a_latency_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (timing.extra_latency == (($past(s_reg.read_strategy) == 2'b11) ? 2'h2 :
             ($past(s_reg.read_strategy) == 2'b10) ? 2'h1 : 2'h0)))
        else $error("extra latency wrong");

    a_strategy_dly: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (timing.cmd_delayed == ($past(s_reg.read_strategy) != 2'b00)))
        else $error("command delay select wrong");

    a_reload_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.refresh_interval != 11'h000 && s_reg.prescale == SDRTC_PRESCALE_LAST && s_reg.count <= 11'h001)
        |=> s_reg.count == $past(s_reg.refresh_interval) && s_reg.pending)
        else $error("refresh reload spacing wrong");

    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:11] == 21'h000000)
        else $error("upper read bits not zero");

    // =====================================================================
    // register and refresh checks
    a_done_state: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> s_reg.st == SDRTC_ST_DONE)
        else $error("ready outside completing cycle");

    a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without ready");

    a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pslverr) |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && pslverr) |=> $stable(refresh_interval) && $stable(s_reg.read_strategy)
        && $stable(s_reg.precharge) && $stable(s_reg.act2pre) && $stable(s_reg.srexit))
        else $error("unmapped write changed a field");

    a_write_refresh: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == SDRTC_OFF_REFRESH) |=> refresh_interval == $past(pwdata[10:0]))
        else $error("refresh write lost");

    a_write_readcfg: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == SDRTC_OFF_READCFG) |=> s_reg.read_strategy == $past(pwdata[1:0]))
        else $error("strategy write lost");

    a_write_prechg: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == SDRTC_OFF_PRECHG) |=> s_reg.precharge == $past(pwdata[3:0]))
        else $error("precharge write lost");

    a_write_act2pre: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == SDRTC_OFF_ACT2PRE) |=> s_reg.act2pre == $past(pwdata[3:0]))
        else $error("active to precharge write lost");

    a_write_srexit: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == SDRTC_OFF_SREXIT) |=> s_reg.srexit == $past(pwdata[3:0]))
        else $error("self refresh exit write lost");

    a_read_refresh: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == SDRTC_OFF_REFRESH) |-> prdata[10:0] == refresh_interval)
        else $error("refresh read wrong");

    a_read_readcfg: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == SDRTC_OFF_READCFG) |-> prdata[1:0] == s_reg.read_strategy)
        else $error("strategy read wrong");

    a_read_prechg: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == SDRTC_OFF_PRECHG) |-> prdata[3:0] == s_reg.precharge)
        else $error("precharge read wrong");

    a_read_act2pre: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == SDRTC_OFF_ACT2PRE) |-> prdata[3:0] == s_reg.act2pre)
        else $error("active to precharge read wrong");

    a_read_srexit: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == SDRTC_OFF_SREXIT) |-> prdata[3:0] == s_reg.srexit)
        else $error("self refresh exit read wrong");

    a_feedback_sel: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (timing.use_feedback_clk == ($past(s_reg.read_strategy) != 2'b00)))
        else $error("feedback clock select wrong");

    a_shared_timing: assert property (@(posedge pclk) disable iff (!presetn)
        ($stable(s_reg.read_strategy) && $stable(s_reg.precharge) && $stable(s_reg.act2pre)
         && $stable(s_reg.srexit)) |=> $stable(timing))
        else $error("shared timing moved on its own");

    a_cycles_range: assert property (@(posedge pclk) disable iff (!presetn)
        timing.precharge_cycles != 5'h00 && timing.precharge_cycles <= 5'h10 && timing.act2pre_cycles != 5'h00
        && timing.act2pre_cycles <= 5'h10 && timing.srexit_cycles != 5'h00 && timing.srexit_cycles <= 5'h10)
        else $error("cycle count out of range");

    a_prescale_run: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.refresh_interval != 11'h000 |=> s_reg.prescale == $past(s_reg.prescale) + 4'h1)
        else $error("prescaler stalled");

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.refresh_interval != 11'h000 && s_reg.prescale != SDRTC_PRESCALE_LAST) |=> $stable(s_reg.count))
        else $error("countdown moved between ticks");

    a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.refresh_interval != 11'h000 && s_reg.prescale == SDRTC_PRESCALE_LAST && s_reg.count > 11'h001)
        |=> s_reg.count == $past(s_reg.count) - 11'h001)
        else $error("countdown step wrong");

    a_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.refresh_interval == 11'h000 |=> s_reg.count == 11'h000 && s_reg.prescale == 4'h0 && !s_reg.pending)
        else $error("timer not cleared while disabled");

    a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (refresh_req && !refresh_ack) |=> refresh_req)
        else $error("refresh request dropped unacknowledged");

    a_req_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (refresh_req && refresh_ack) |=> !refresh_req)
        else $error("refresh request held after ack");

    a_req_issue: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.pending && !refresh_req && s_reg.refresh_interval != 11'h000) |=> refresh_req)
        else $error("pending refresh not raised");

    c_write: cover property (@(posedge pclk) disable iff (!presetn) pready && pwrite);
    c_read: cover property (@(posedge pclk) disable iff (!presetn) pready && !pwrite);
    c_refresh: cover property (@(posedge pclk) disable iff (!presetn) refresh_req && refresh_ack);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
    c_slip: cover property (@(posedge pclk) disable iff (!presetn)
        (refresh_req && !refresh_ack) ##1 (refresh_req && !refresh_ack));

endmodule : sdrtc_refresh_timing

// >>> sdrtc_seq_model.sv
`timescale 1ns/100ps
module sdrtc_seq_model
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pacing of the model
    input  wire logic slow,
    // refresh handshake
    input  wire logic refresh_req,
    output logic      refresh_ack
);
    int unsigned wait_cnt;

    // =====================================================================
    // sequencer takes each refresh promptly or after a late delay
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refresh_ack <= 1'b0;
            wait_cnt    <= 0;
        end
        else if (refresh_ack)
        begin
            refresh_ack <= 1'b0;
            wait_cnt    <= slow ? ($urandom % 8) : 0;
        end
        else if (refresh_req && wait_cnt == 0)
            refresh_ack <= 1'b1;
        else if (refresh_req)
            wait_cnt <= wait_cnt - 1;
    end
endmodule : sdrtc_seq_model

// >>> sdrtc_refresh_timing_tb_top.sv
`timescale 1ns/100ps
module sdrtc_refresh_timing_tb_top;
    import sdrtc_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } sdrtc_exp_t;
    localparam logic [11:0] OFFS [5] = '{SDRTC_OFF_REFRESH, SDRTC_OFF_READCFG, SDRTC_OFF_PRECHG,
                                         SDRTC_OFF_ACT2PRE, SDRTC_OFF_SREXIT};
    localparam logic [31:0] MSK [5]  = '{32'h7FF, 32'h3, 32'hF, 32'hF, 32'hF};
    localparam logic [31:0] TAB [3]  = '{32'h0, 32'hE, 32'hF};
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic          refresh_ack, refresh_req;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic [10:0]   refresh_interval;
    sdrtc_timing_t timing;
    logic [31:0]   cur [5];
    sdrtc_exp_t    exp_q [$];
    sdrtc_exp_t    mon_e;
    int            fail_count = 0;
    int            n_tests = 0;

    sdrtc_refresh_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .refresh_ack(refresh_ack), .refresh_req(refresh_req),
        .refresh_interval(refresh_interval), .timing(timing));
    sdrtc_seq_model seq (.pclk(pclk), .presetn(presetn), .slow(slow),
        .refresh_req(refresh_req), .refresh_ack(refresh_ack));

    always #20 pclk = ~pclk;

    // =====================================================================
    // checking
    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [18:0] tm_exp();
        logic [1:0] s;
        s = cur[1][1:0];
        return {s != 2'h0, s != 2'h0, (s == 2'h0) ? 2'h0 : s - 2'h1, {1'b0, cur[2][3:0]} + 5'h01,
                {1'b0, cur[3][3:0]} + 5'h01, {1'b0, cur[4][3:0]} + 5'h01};
    endfunction : tm_exp

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            mon_e = exp_q.pop_front();
            chk("prdata", mon_e.data, prdata & mon_e.mask);
            chk("pslverr", {31'h0, mon_e.err}, {31'h0, pslverr});
        end
    end

    // =====================================================================
    // apb master, psel kept high for back-to-back transfers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int w;
        w = 0;
        exp_q.push_back('{d & m, m, e});
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wr ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        penable <= 1'b0;
        chk("access cycles", 32'h2, w);
        if (w >= 20)
            give_verdict();
    endtask : apb

    task automatic rel();
        psel <= 1'b0;
        @(posedge pclk);
    endtask : rel

    task automatic rst_chk();
        int i;
        cur = '{32'h0, 32'h0, 32'hF, 32'hF, 32'hF};
        for (i = 0; i < 5; i++)
            apb(1'b0, OFFS[i], cur[i], MSK[i], 1'b0);
        apb(1'b0, SDRTC_OFF_STATUS, 32'h0, 32'h7FF, 1'b0);
        rel();
        chk("timing", {13'h0, tm_exp()}, {13'h0, timing});
    endtask : rst_chk

    task automatic quiet();
        int k;
        k = 0;
        repeat (40) @(posedge pclk);
        repeat (300)
        begin
            @(posedge pclk);
            if (refresh_req !== 1'b0)
                k++;
        end
        chk("refresh idle", 32'h0, k);
    endtask : quiet

    task automatic meas(input int n, input int tol);
        int t, k, cyc, d;
        logic prev;
        apb(1'b1, OFFS[0], n, 32'h0, 1'b0);
        rel();
        chk("interval out", n, {21'h0, refresh_interval});
        prev = refresh_req;
        k = -1;
        cyc = 0;
        for (t = 0; t < 2000 && k < 4; t++)
        begin
            @(posedge pclk);
            if (refresh_req === 1'b1 && prev !== 1'b1)
                k++;
            if (k >= 0)
                cyc++;
            prev = refresh_req;
        end
        d = cyc - 64 * n - 1;
        chk("refresh spacing", 32'h1, {31'h0, d <= tol && d >= -tol});
        if (k < 4)
            give_verdict();
    endtask : meas

    // =====================================================================
    // main sequence
    initial
    begin
        int r, k;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; slow = 1'b0;
        void'($urandom(32'hD1A5D873));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        quiet();
        rst_chk();
        for (r = 1; r < 5; r++)
        begin
            for (k = 0; k < 4; k++)
            begin
                cur[r] = (r == 1) ? k : ((k == 3) ? ($urandom % 16) : TAB[k]);
                apb(1'b1, OFFS[r], cur[r], 32'h0, 1'b0);
                apb(1'b0, OFFS[r], cur[r], MSK[r], 1'b0);
                rel();
                chk("timing", {13'h0, tm_exp()}, {13'h0, timing});
            end
        end
        apb(1'b1, 12'h018, 32'h1, 32'h0, 1'b1);
        apb(1'b0, 12'h018, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b0, OFFS[4], cur[4], MSK[4], 1'b0);
        rel();
        meas(1, 2);
        meas(5, 2);
        slow <= 1'b1;
        meas(2, 10);
        slow <= 1'b0;
        apb(1'b1, OFFS[0], 32'h0, 32'h0, 1'b0);
        rel();
        quiet();
        meas(3, 2);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        quiet();
        give_verdict();
    end
endmodule : sdrtc_refresh_timing_tb_top
